// >>> rsc_defines.vh
// constants of the reset strap configuration latch
//----------------------------------------------------------------------
// Operation
// R1: strap-capable address pins are inputs during capture, driven addresses afterwards
// R2: straps on pins 6 and 0 choose internal CPU or external CPU path
// R3: strap pin 1 low holds core reset until PLL reports stable lock
// R4: strap pin 1 high holds core reset exactly 32 clock cycles, test only
// R5: straps on pins 5..2 choose boot source NOR, UART, IN_SYSTEM_PROGRAM_BOOT, NAND or SPI
// R6: strap pin 7 high turns GPIO 4 and 3 into UART transmit and receive
// R7: straps latched once at end of capture, held until next chip reset
//----------------------------------------------------------------------
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// strap bit positions inside the captured byte
`define RSC_STRAP_CPU_LO 0
`define RSC_STRAP_FAST 1
`define RSC_STRAP_BOOT_LO 2
`define RSC_STRAP_BOOT_HI 5
`define RSC_STRAP_CPU_HI 6
`define RSC_STRAP_UART 7
`define RSC_STRAP_W 8
`define RSC_ADDR_W 15

// cpu selection codes
`define RSC_CPU_INTERNAL 2'h0
`define RSC_CPU_EXT_PORT 2'h2
`define RSC_CPU_EXT_SENSOR 2'h3

// boot source codes
`define RSC_BOOT_NOR 3'h0
`define RSC_BOOT_UART 3'h1
`define RSC_BOOT_ISP 3'h2
`define RSC_BOOT_NAND 3'h3
`define RSC_BOOT_SPI 3'h4

// timing: clock period in ps, capture window in ns, fast reset in cycles
`define RSC_CLK_PERIOD_PS 4000
`define RSC_CAPTURE_NS 32
`define RSC_CAPTURE_CYC ((`RSC_CAPTURE_NS * 1000) / `RSC_CLK_PERIOD_PS)
`define RSC_FAST_RST_CYC 32

// register byte offsets
`define RSC_REG_STRAP 12'h000
`define RSC_REG_DECODE 12'h004
`define RSC_REG_CTRL 12'h008
`define RSC_REG_STATUS 12'h00C

// control register fields and reset value
`define RSC_CTRL_CORE_HOLD 0
`define RSC_CTRL_UART_OFF 1
`define RSC_CTRL_RESET 2'h0

// axi responses
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

`endif

// >>> rsc_pad_sync.v
// two-stage synchroniser for the pin inputs seen by the strap latch
`timescale 1ns/1ps
module rsc_pad_sync (
    input wire clk_sys_i,
    input wire srst_i,
    input wire [10:0] pad_i,
    output wire [10:0] pad_sync_o
);
    reg [10:0] meta_q;
    reg [10:0] sync_q;

    // first stage is read by the second stage only
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_q <= 11'h000;
            sync_q <= 11'h000;
        end else begin
            meta_q <= pad_i;
            sync_q <= meta_q;
        end
    end

    assign pad_sync_o = sync_q;
endmodule

// >>> rsc_strap_latch.v
// reset strap capture, core reset sequencing and axi4-lite status/control
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_strap_latch (
    input wire clk_sys_i,
    input wire srst_i,
    // sdram address pins
    input wire [7:0] sdram_addr_bus_i,
    output reg [14:0] sdram_addr_bus_o,
    output reg [14:0] sdram_addr_bus_oe_o,
    input wire [14:0] mem_addr_i,
    // pll and core reset
    input wire pll_lock_i,
    output reg core_rst_o,
    // decoded configuration
    output reg [1:0] cpu_sel_o,
    output reg int_cpu_en_o,
    output reg [2:0] boot_sel_o,
    output reg uart_on_gpio_o,
    // gpio 4 and 3 pins, index 0 is gpio 3
    input wire [1:0] gpio34_i,
    output reg [1:0] gpio34_o,
    output reg [1:0] gpio34_oe_o,
    input wire [1:0] gpio34_out_i,
    input wire [1:0] gpio34_dir_i,
    output reg [1:0] gpio34_in_o,
    input wire uart_txd_i,
    output reg uart_rxd_o,
    // axi4-lite slave
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    //------------------------------------------------------------------
    // functions
    //------------------------------------------------------------------
    function [2:0] boot_decode;
        input [3:0] b;
        begin
            if (b[1])
                boot_decode = `RSC_BOOT_NOR;
            else if (b[3])
                boot_decode = `RSC_BOOT_UART;
            else if (b[2])
                boot_decode = `RSC_BOOT_ISP;
            else if (b[0])
                boot_decode = `RSC_BOOT_SPI;
            else
                boot_decode = `RSC_BOOT_NAND;
        end
    endfunction

    // the unlisted code 2'b01 falls back to the internal cpu
    function [1:0] cpu_decode;
        input hi;
        input lo;
        begin
            if (hi && lo)
                cpu_decode = `RSC_CPU_EXT_SENSOR;
            else if (hi)
                cpu_decode = `RSC_CPU_EXT_PORT;
            else
                cpu_decode = `RSC_CPU_INTERNAL;
        end
    endfunction

    function addr_known;
        input [11:0] a;
        begin
            addr_known = (a == `RSC_REG_STRAP) || (a == `RSC_REG_DECODE) ||
                         (a == `RSC_REG_CTRL) || (a == `RSC_REG_STATUS);
        end
    endfunction

    //------------------------------------------------------------------
    // states
    //------------------------------------------------------------------
    localparam [2:0] ST_CAPT = 3'h1;
    localparam [2:0] ST_HOLD = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;
    localparam integer CAPT_LAST_I = `RSC_CAPTURE_CYC - 1;
    localparam integer FAST_LAST_I = `RSC_FAST_RST_CYC - 1;
    localparam [7:0] CAPT_LAST = CAPT_LAST_I[7:0];
    localparam [5:0] FAST_LAST = FAST_LAST_I[5:0];

    wire [10:0] pad_sync;
    wire [7:0] strap_sync;
    wire pll_lock_s;
    wire [1:0] gpio34_s;

    reg [2:0] state_q;
    reg [7:0] capt_cnt_q;
    reg [5:0] fast_cnt_q;
    reg [7:0] strap_q;
    reg drive_q;
    reg hold_q;
    reg [1:0] ctrl_q;
    reg uart_en;

    rsc_pad_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .pad_i({gpio34_i, pll_lock_i, sdram_addr_bus_i}),
        .pad_sync_o(pad_sync)
    );

    assign strap_sync = pad_sync[7:0];
    assign pll_lock_s = pad_sync[8];
    assign gpio34_s = pad_sync[10:9];

    //------------------------------------------------------------------
    // capture and core reset sequencing
    //------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= ST_CAPT;
            capt_cnt_q <= 8'h00;
            fast_cnt_q <= 6'h00;
            strap_q <= 8'h00;
            drive_q <= 1'b0;
            hold_q <= 1'b1;
        end else begin
            case (state_q)
                ST_CAPT: begin
                    // window covers the synchroniser delay plus settling of the pulls
                    if (capt_cnt_q == CAPT_LAST) begin
                        strap_q <= strap_sync; // R7
                        drive_q <= 1'b1; // R1
                        state_q <= ST_HOLD;
                    end else begin
                        capt_cnt_q <= capt_cnt_q + 8'h01;
                    end
                end
                ST_HOLD: begin
                    if (strap_q[`RSC_STRAP_FAST]) begin
                        if (fast_cnt_q == FAST_LAST) begin // R4
                            hold_q <= 1'b0;
                            state_q <= ST_RUN;
                        end else begin
                            fast_cnt_q <= fast_cnt_q + 6'h01;
                        end
                    end else if (pll_lock_s) begin // R3
                        hold_q <= 1'b0;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    hold_q <= 1'b0;
                end
                default: begin
                    state_q <= ST_CAPT;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // pin and configuration outputs
    //------------------------------------------------------------------
    always @* begin
        uart_en = strap_q[`RSC_STRAP_UART] & ~ctrl_q[`RSC_CTRL_UART_OFF];
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            sdram_addr_bus_o <= 15'h0000;
            sdram_addr_bus_oe_o <= 15'h0000;
            core_rst_o <= 1'b1;
            cpu_sel_o <= `RSC_CPU_INTERNAL;
            int_cpu_en_o <= 1'b1;
            boot_sel_o <= `RSC_BOOT_NOR;
            uart_on_gpio_o <= 1'b0;
            gpio34_o <= 2'h0;
            gpio34_oe_o <= 2'h0;
            gpio34_in_o <= 2'h0;
            uart_rxd_o <= 1'b1;
        end else begin
            // strap pins stay undriven until the straps are latched
            sdram_addr_bus_o <= drive_q ? mem_addr_i : 15'h0000; // R1
            sdram_addr_bus_oe_o <= {7'h7F, {8{drive_q}}}; // R1
            core_rst_o <= hold_q | ctrl_q[`RSC_CTRL_CORE_HOLD]; // R3 R4
            cpu_sel_o <= cpu_decode(strap_q[`RSC_STRAP_CPU_HI], strap_q[`RSC_STRAP_CPU_LO]); // R2
            int_cpu_en_o <= ~strap_q[`RSC_STRAP_CPU_HI]; // R2
            boot_sel_o <= boot_decode(strap_q[`RSC_STRAP_BOOT_HI:`RSC_STRAP_BOOT_LO]); // R5
            uart_on_gpio_o <= uart_en; // R6
            gpio34_in_o <= gpio34_s;
            if (uart_en) begin // R6
                gpio34_o <= {uart_txd_i, 1'b0};
                gpio34_oe_o <= 2'h2;
                uart_rxd_o <= gpio34_s[0];
            end else begin
                gpio34_o <= gpio34_out_i;
                gpio34_oe_o <= gpio34_dir_i;
                uart_rxd_o <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // axi4-lite write channel
    //------------------------------------------------------------------
    reg aw_have_q;
    reg w_have_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire aw_take;
    wire w_take;
    wire wr_do;
    reg aw_have_d;
    reg w_have_d;
    reg bvalid_d;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_do = aw_have_q & w_have_q & ~s_axi_bvalid;

    always @* begin
        aw_have_d = (aw_have_q | aw_take) & ~wr_do;
        w_have_d = (w_have_q | w_take) & ~wr_do;
        bvalid_d = wr_do | (s_axi_bvalid & ~s_axi_bready);
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSC_RESP_OKAY;
            ctrl_q <= `RSC_CTRL_RESET;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            s_axi_bvalid <= bvalid_d;
            // each channel reopens only after the response is accepted
            s_axi_awready <= ~aw_have_d & ~bvalid_d;
            s_axi_wready <= ~w_have_d & ~bvalid_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                if ({awaddr_q[11:2], 2'h0} == `RSC_REG_CTRL) begin
                    s_axi_bresp <= `RSC_RESP_OKAY;
                    if (wstrb_q[0]) begin
                        ctrl_q <= wdata_q[1:0];
                    end
                end else if (addr_known({awaddr_q[11:2], 2'h0})) begin
                    s_axi_bresp <= `RSC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RSC_RESP_SLVERR;
                end
            end
        end
    end

    //------------------------------------------------------------------
    // axi4-lite read channel
    //------------------------------------------------------------------
    wire ar_take;
    wire [11:0] rd_addr;
    reg [31:0] rd_word;

    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_addr = {s_axi_araddr[11:2], 2'h0};

    always @* begin
        if (rd_addr == `RSC_REG_STRAP) begin
            rd_word = {24'h000000, strap_q};
        end else if (rd_addr == `RSC_REG_DECODE) begin
            rd_word = {24'h000000, uart_en, boot_sel_o, int_cpu_en_o, 1'b0, cpu_sel_o};
        end else if (rd_addr == `RSC_REG_CTRL) begin
            rd_word = {30'h00000000, ctrl_q};
        end else if (rd_addr == `RSC_REG_STATUS) begin
            rd_word = {24'h000000, core_rst_o, pll_lock_s, drive_q, 2'h0, state_q};
        end else begin
            rd_word = 32'h00000000;
        end
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RSC_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= addr_known(rd_addr) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else begin
                s_axi_arready <= ~s_axi_rvalid;
            end
        end
    end
endmodule

// >>> rsc_board_pulls.sv
// board pull resistors that strap the low address pins
`timescale 1ns/1ps
module rsc_board_pulls (
    input wire [7:0] strap_i,
    input wire [7:0] oe_i,
    input wire [7:0] drv_i,
    output wire [7:0] pin_o
);
    // an undriven pin rests at its resistor level, a driven one follows the device
    assign pin_o = (oe_i & drv_i) | (~oe_i & strap_i);
endmodule

// >>> rsc_strap_checker.sv
// concurrent checks on strap capture, decode, core reset and gpio muxing
`timescale 1ns/1ps
module rsc_strap_checker (
    input wire clk_sys_i,
    input wire srst_i,
    input wire [7:0] sdram_addr_bus_i,
    input wire [14:0] sdram_addr_bus_o,
    input wire [14:0] sdram_addr_bus_oe_o,
    input wire [14:0] mem_addr_i,
    input wire pll_lock_i,
    input wire core_rst_o,
    input wire [1:0] cpu_sel_o,
    input wire int_cpu_en_o,
    input wire uart_on_gpio_o,
    input wire [1:0] gpio34_o,
    input wire [1:0] gpio34_oe_o,
    input wire uart_txd_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    //----------------------------------------------------------------
    // helper
    //----------------------------------------------------------------
    logic [7:0] strap_q;
    wire drv = sdram_addr_bus_oe_o[7:0] == 8'hFF;
    // pins only show straps while undriven, so freeze the copy once driving
    always_ff @(posedge clk_sys_i) begin
        if (!drv) strap_q <= sdram_addr_bus_i;
    end
    //----------------------------------------------------------------
    // properties
    //----------------------------------------------------------------
    chk_capture_inputs: assert property (
        $fell(srst_i) |-> (sdram_addr_bus_oe_o[7:0] == 8'h00)[*8] ##[1:2] drv)
        else $error("strap pins not released during capture");
    chk_addr_follow: assert property (
        drv && $past(drv) |-> sdram_addr_bus_o == $past(mem_addr_i))
        else $error("address pins do not carry memory address");
    chk_straps_held: assert property (
        drv |=> $stable(cpu_sel_o) && $stable(uart_on_gpio_o))
        else $error("decoded straps changed while running");
    chk_cpu_enable: assert property (
        $rose(drv) |-> int_cpu_en_o == (cpu_sel_o == 2'h0) && cpu_sel_o == ({strap_q[6], strap_q[0]} == 2'b10 ?
            2'h2 : {strap_q[6], strap_q[0]} == 2'b11 ? 2'h3 : 2'h0))
        else $error("cpu selection does not match straps");
    chk_fast_reset: assert property (
        $rose(drv) && strap_q[1] |-> (core_rst_o throughout ##31 1'b1) ##1 !core_rst_o)
        else $error("fast core reset length wrong");
    chk_lock_wait: assert property (
        $fell(core_rst_o) && !strap_q[1] |-> $past(pll_lock_i, 2))
        else $error("core reset released without pll lock");
    chk_lock_release: assert property (
        drv && !strap_q[1] && pll_lock_i && $past(pll_lock_i, 8) |-> !core_rst_o)
        else $error("core reset held after pll lock");
    chk_uart_flag: assert property (
        $rose(drv) |-> uart_on_gpio_o == strap_q[7])
        else $error("uart mode does not match strap");
    chk_uart_tx: assert property (
        uart_on_gpio_o && $past(uart_on_gpio_o) |-> gpio34_oe_o[1] && gpio34_o[1] == $past(uart_txd_i))
        else $error("gpio4 does not carry uart transmit");
endmodule

bind rsc_strap_latch rsc_strap_checker chk_u (.*);

// >>> tb_top.sv
// strap latch bench: strap table, pin turn-round, gpio/uart and register access
`timescale 1ns/1ps
`include "rsc_defines.vh"
module tb_top;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] strap = 8'h00;
    logic [14:0] mem_addr = 15'h0000;
    logic pll_lock = 1'b0, txd = 1'b1;
    logic [1:0] gp_out = 2'h0, gp_dir = 2'h0, gp_ext = 2'h3;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire [7:0] pin;
    wire [14:0] addr_o, addr_oe;
    wire [1:0] gp_o, gp_oe, gp_in, gp_pin, cpu_sel, bresp, rresp;
    wire [2:0] boot_sel;
    wire [31:0] rdata;
    wire core_rst, int_en, uart_on, rxd, awready, wready, bvalid, arready, rvalid;
    logic [7:0] vecs [6] = '{8'h00, 8'h45, 8'hE2, 8'h11, 8'h88, 8'h2A};
    int error_cnt = 0;
    int num_checks = 0;

    assign gp_pin = (gp_oe & gp_o) | (~gp_oe & gp_ext);
    rsc_board_pulls brd_u (.strap_i(strap), .oe_i(addr_oe[7:0]), .drv_i(addr_o[7:0]), .pin_o(pin));
    rsc_strap_latch dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sdram_addr_bus_i(pin),
        .sdram_addr_bus_o(addr_o), .sdram_addr_bus_oe_o(addr_oe), .mem_addr_i(mem_addr), .pll_lock_i(pll_lock),
        .core_rst_o(core_rst), .cpu_sel_o(cpu_sel), .int_cpu_en_o(int_en), .boot_sel_o(boot_sel),
        .uart_on_gpio_o(uart_on), .gpio34_i(gp_pin), .gpio34_o(gp_o), .gpio34_oe_o(gp_oe),
        .gpio34_out_i(gp_out), .gpio34_dir_i(gp_dir), .gpio34_in_o(gp_in), .uart_txd_i(txd), .uart_rxd_o(rxd),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    //----------------------------------------------------------------
    // tasks
    //----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic chk(input string what, input [31:0] exp, input [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic axi_wr(input [11:0] a, input [31:0] d, output [1:0] resp);
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input [11:0] a, output [31:0] d, output [1:0] resp);
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic run_vec(input [7:0] s);
        logic [31:0] d;
        logic [1:0] r, ec;
        logic [2:0] eb;
        ec = {s[6], s[0]} == 2'b10 ? `RSC_CPU_EXT_PORT : {s[6], s[0]} == 2'b11 ? `RSC_CPU_EXT_SENSOR : `RSC_CPU_INTERNAL;
        eb = s[3] ? `RSC_BOOT_NOR : s[5] ? `RSC_BOOT_UART : s[4] ? `RSC_BOOT_ISP : s[2] ? `RSC_BOOT_SPI : `RSC_BOOT_NAND;
        strap <= s;
        pll_lock <= 1'b0;
        txd <= 1'b1;
        gp_ext <= 2'h3;
        srst_i <= 1'b1;
        cyc(20);
        srst_i <= 1'b0;
        cyc(4);
        chk("oe_capture", 8'h00, addr_oe[7:0]);
        cyc(50);
        chk("oe_run", 15'h7FFF, addr_oe);
        mem_addr <= 15'h2A5C;
        cyc(2);
        chk("addr_out", 15'h2A5C, addr_o);
        chk("pins", 8'h5C, pin);
        chk("core_rst", !s[1], core_rst);
        pll_lock <= 1'b1;
        cyc(10);
        chk("core_rst_lock", 1'b0, core_rst);
        chk("cpu_sel", ec, cpu_sel);
        chk("int_cpu", ec == 2'h0, int_en);
        chk("boot_sel", eb, boot_sel);
        chk("uart_on", s[7], uart_on);
        // pins now show driven addresses; the latched view must not move
        strap <= ~s;
        mem_addr <= 15'h05A3;
        cyc(8);
        axi_rd(`RSC_REG_STRAP, d, r);
        chk("strap_reg", {24'h0, s}, d);
        axi_rd(`RSC_REG_DECODE, d, r);
        chk("decode_reg", {24'h0, s[7], eb, ec == 2'h0, 1'b0, ec}, d);
        chk("boot_held", eb, boot_sel);
        txd <= 1'b0;
        gp_ext <= 2'h2;
        gp_out <= 2'h1;
        gp_dir <= 2'h1;
        cyc(6);
        if (s[7]) begin
            chk("gpio4_tx", 2'h2, {gp_oe[1], gp_o[1]});
            chk("gpio3_rx", 1'b0, rxd);
        end else begin
            chk("gpio_drive", 4'h5, {gp_oe, gp_o});
            chk("gpio_in", 2'h3, gp_in);
            chk("rx_idle", 1'b1, rxd);
        end
        $display("test strap %h done, mismatches %0d", s, error_cnt);
    endtask

    task automatic reg_test;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`RSC_REG_CTRL, 32'h1, r);
        chk("ctrl_wr_resp", `RSC_RESP_OKAY, r);
        axi_rd(`RSC_REG_CTRL, d, r);
        chk("ctrl_rd", 32'h1, d);
        chk("forced_rst", 1'b1, core_rst);
        axi_wr(`RSC_REG_CTRL, 32'h2, r);
        axi_rd(`RSC_REG_CTRL, d, r);
        chk("ctrl_uart_off", 32'h2, d);
        chk("forced_rst_off", 1'b0, core_rst);
        chk("uart_off_flag", 1'b0, uart_on);
        axi_wr(`RSC_REG_CTRL, 32'h0, r);
        axi_wr(`RSC_REG_STRAP, 32'hFF, r);
        chk("ro_wr_resp", `RSC_RESP_OKAY, r);
        axi_rd(`RSC_REG_STRAP, d, r);
        chk("ro_kept", 32'h2A, d);
        axi_rd(12'h010, d, r);
        chk("unmapped_rd", `RSC_RESP_SLVERR, r);
        chk("unmapped_data", 32'h0, d);
        axi_wr(12'h010, 32'h1, r);
        chk("unmapped_wr", `RSC_RESP_SLVERR, r);
        $display("test registers done, mismatches %0d", error_cnt);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    //----------------------------------------------------------------
    // run
    //----------------------------------------------------------------
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // the whole run needs about 700 cycles; this cuts a hang well after that
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end

    initial begin
        @(posedge clk_sys_i);
        foreach (vecs[i]) run_vec(vecs[i]);
        reg_test();
        finish_test();
    end
endmodule
